// ==== tsm_slot_mapper.sv ====
/*
 * TDM slot mapper: maps the time slot layer frame onto a bypass or tunnel
 * frame (source) and back (sink) through per-direction slot tables, with a
 * synchronous direct or asynchronous elastic-store channel in front.
 * Assumes slot ticks and frame starts are synchronous to clk, at most
 * 16 slots per frame, and that frameStart is only raised with slotEn.
 */
`timescale 1ns/10ps
`include "tsm_defines.svh"

module tsm_slot_mapper (
	// Clock, reset, enable
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire logic                          ce,
	// Configuration levels
	input  wire tsm_pkg::tsm_map_mode_type     mapMode,
	input  wire logic                          tunnelSel,
	input  wire logic                          channelAsync,
	// Management slot table write port
	input  wire logic                          mgmtSlotTableWe,
	input  wire logic                          mgmtSlotTableDir,
	input  wire logic [`TSM_IDX_W-1:0]         mgmtSlotTableIdx,
	input  wire tsm_pkg::tsm_map_entry_type    mgmtSlotTableInput,
	// Channel side
	input  wire tsm_pkg::tsm_stream_type       syncChannelWords,
	input  wire logic [`TSM_WORD_W-1:0]        asyncChannelWords,
	input  wire logic                          asyncChannelValid,
	input  wire logic                          frameStartPulse,
	input  wire logic                          slotTick,
	// Adapted frames towards and from the far layers
	output tsm_pkg::tsm_stream_type            bypassAdaptedWords,
	output tsm_pkg::tsm_stream_type            tunnelAdaptedWords,
	input  wire tsm_pkg::tsm_stream_type       bypassAdaptedIn,
	input  wire tsm_pkg::tsm_stream_type       tunnelAdaptedIn,
	// Time slot layer words delivered by the sink direction
	output tsm_pkg::tsm_stream_type            timeSlotClientWords,
	// Status
	output logic                               esOverflow
);

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------

	// Monotonic mode accepts a source index only above the last one used
	function automatic logic orderOk(input tsm_pkg::tsm_map_mode_type mode,
	                                 input logic [`TSM_IDX_W-1:0] src,
	                                 input logic [`TSM_IDX_W-1:0] last,
	                                 input logic seen);
		orderOk = (mode == tsm_pkg::TSM_ARBITRARY) || !seen || (src > last);
	endfunction : orderOk

	// Slot position of the current occasion
	function automatic logic [`TSM_IDX_W-1:0] slotOf(input logic fs,
	                                                 input logic [`TSM_IDX_W-1:0] cnt);
		slotOf = fs ? '0 : cnt;
	endfunction : slotOf

	localparam tsm_pkg::tsm_stream_type IDLE_STREAM = '{frameStart: 1'b0, slotEn: 1'b0,
	                                                    word: `TSM_IDLE_WORD};

	tsm_pkg::tsm_stream_type    asyncTs;
	tsm_pkg::tsm_stream_type    dirIn   [0:1];
	tsm_pkg::tsm_stream_type    dirNext [0:1];
	tsm_pkg::tsm_map_entry_type entryW  [0:1];
	tsm_pkg::tsm_map_entry_type shadow0W[0:1];
	tsm_pkg::tsm_map_entry_type active0W[0:1];
	logic                       mappedW [0:1];
	logic                       fsW     [0:1];
	logic                       seenW   [0:1];
	logic [`TSM_IDX_W-1:0]      lastW   [0:1];

	// ------------------------------------------------------------------------
	// Channel adaptation in front of the source direction
	// ------------------------------------------------------------------------
	tsm_async_mapper u_async (
		.clk               (clk),
		.rstn              (rstn),
		.ce                (ce),
		.asyncChannelWords (asyncChannelWords),
		.asyncChannelValid (asyncChannelValid),
		.frameStartPulse   (frameStartPulse),
		.slotTick          (slotTick),
		.tsOut             (asyncTs),
		.esOverflow        (esOverflow)
	);

	// Synchronous frame passes straight into the time slot layer frame
	assign dirIn[0] = channelAsync ? asyncTs : syncChannelWords;
	// Sink reads from whichever adapted layer is selected
	assign dirIn[1] = tunnelSel ? tunnelAdaptedIn : bypassAdaptedIn;

	// ------------------------------------------------------------------------
	// Slot mapping, one instance per direction with its own table
	// ------------------------------------------------------------------------
	for (genvar d = 0; d < 2; d++) begin : g_dir
		// Double-buffered frame store: one bank fills while the other is
		// read, costing one frame of delay but allowing any permutation.
		logic [`TSM_WORD_W-1:0]     frameBuf [0:1][0:`TSM_SLOT_CNT-1];
		tsm_pkg::tsm_map_entry_type shadowTbl[0:`TSM_SLOT_CNT-1];
		tsm_pkg::tsm_map_entry_type activeTbl[0:`TSM_SLOT_CNT-1];
		logic                       bank_q;
		logic [`TSM_IDX_W-1:0]      slot_q;
		logic [`TSM_IDX_W-1:0]      lastSrc_q;
		logic                       seen_q;
		logic                       fs;
		logic                       wb;
		logic                       seen;
		logic [`TSM_IDX_W-1:0]      cur;
		tsm_pkg::tsm_map_entry_type entry;
		logic                       mapped;

		// Current occasion decode
		assign fs     = dirIn[d].frameStart && dirIn[d].slotEn;
		assign cur    = slotOf(fs, slot_q);
		assign wb     = fs ? ~bank_q : bank_q;
		assign seen   = fs ? 1'b0 : seen_q;
		assign entry  = fs ? shadowTbl[0] : activeTbl[cur];
		assign mapped = !entry.excess && orderOk(mapMode, entry.srcSlot, lastSrc_q, seen);

		// Incoming words land at their own slot position
		always_ff @(posedge clk) begin
			if (ce && dirIn[d].slotEn) begin
				frameBuf[wb][cur] <= dirIn[d].word;
			end
		end

		// Slot counter and bank swap on frame start
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				slot_q <= '0;
				bank_q <= 1'b0;
			end else if (ce && dirIn[d].slotEn) begin
				slot_q <= cur + 1'b1;
				bank_q <= wb;
			end
		end

		// Management writes the shadow table at any time
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				for (int i = 0; i < `TSM_SLOT_CNT; i++) shadowTbl[i] <= '{excess: 1'b1, srcSlot: '0};
			end else if (ce && mgmtSlotTableWe && mgmtSlotTableDir == 1'(d)) begin
				shadowTbl[mgmtSlotTableIdx] <= mgmtSlotTableInput;
			end
		end

		// Active table follows the shadow only at a frame boundary
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				for (int i = 0; i < `TSM_SLOT_CNT; i++) activeTbl[i] <= '{excess: 1'b1, srcSlot: '0};
			end else if (ce && fs) begin
				for (int i = 0; i < `TSM_SLOT_CNT; i++) activeTbl[i] <= shadowTbl[i];
			end
		end

		// Order tracking for monotonic mode within one frame
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				lastSrc_q <= '0;
				seen_q    <= 1'b0;
			end else if (ce && dirIn[d].slotEn) begin
				seen_q <= mapped || seen;
				if (mapped) lastSrc_q <= entry.srcSlot;
			end
		end

		// Next output word: previous frame's source slot, or idle if excess or refused by the order check
		always_comb begin
			dirNext[d]            = IDLE_STREAM;
			dirNext[d].slotEn     = dirIn[d].slotEn;
			dirNext[d].frameStart = fs;
			if (dirIn[d].slotEn && mapped) begin
				dirNext[d].word = frameBuf[~wb][entry.srcSlot];
			end
		end

		assign entryW[d]   = entry;
		assign mappedW[d]  = mapped;
		assign fsW[d]      = fs;
		assign seenW[d]    = seen;
		assign lastW[d]    = lastSrc_q;
		assign shadow0W[d] = shadowTbl[0];
		assign active0W[d] = activeTbl[0];
	end

	// ------------------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------------------

	// Source frame goes to the selected layer; the other carries idle words
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bypassAdaptedWords <= IDLE_STREAM;
			tunnelAdaptedWords <= IDLE_STREAM;
		end else if (ce) begin
			bypassAdaptedWords <= tunnelSel ? IDLE_STREAM : dirNext[0];
			tunnelAdaptedWords <= tunnelSel ? dirNext[0] : IDLE_STREAM;
		end
	end

	// Sink frame back to the time slot layer; access to channel is direct
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			timeSlotClientWords <= IDLE_STREAM;
		end else if (ce) begin
			timeSlotClientWords <= dirNext[1];
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_src_excess;
		ce && dirIn[0].slotEn && entryW[0].excess;
	endsequence

	sequence s_src_idle_out;
		($past(tunnelSel) ? tunnelAdaptedWords.word : bypassAdaptedWords.word) == `TSM_IDLE_WORD;
	endsequence

	a_src_excess_idle: assert property (s_src_excess |=> s_src_idle_out)
		else $error("excess source slot not idle");
	a_tun_excess_idle: assert property (s_src_excess ##0 tunnelSel |=>
		tunnelAdaptedWords.slotEn && tunnelAdaptedWords.word == `TSM_IDLE_WORD)
		else $error("excess tunnel slot not idle");
	a_snk_excess_idle: assert property (ce && dirIn[1].slotEn && entryW[1].excess |=>
		timeSlotClientWords.word == `TSM_IDLE_WORD) else $error("excess sink slot not idle");
	a_slot_per_occ: assert property (ce && dirIn[1].slotEn |=>
		timeSlotClientWords.slotEn ##1 1'b1) else $error("sink slot occasion lost");
	a_frame_mark: assert property (ce && fsW[0] && !tunnelSel |=>
		bypassAdaptedWords.frameStart && bypassAdaptedWords.slotEn) else $error("frame start not carried");
	a_table_load: assert property (ce && fsW[1] |=>
		active0W[1] == $past(shadow0W[1])) else $error("table not loaded at frame start");
	a_table_hold: assert property (ce && !fsW[0] |=>
		active0W[0] == $past(active0W[0])) else $error("table changed inside a frame");
	a_mono_order: assert property (ce && mapMode == tsm_pkg::TSM_MONOTONIC && dirIn[0].slotEn
		&& mappedW[0] && seenW[0] |-> entryW[0].srcSlot > lastW[0])
		else $error("monotonic order broken");
	a_dir_indep: assert property (ce && mgmtSlotTableWe && mgmtSlotTableDir == `TSM_DIR_SRC |=>
		shadow0W[1] == $past(shadow0W[1])) else $error("source write reached sink table");

	// ------------------------------------------------------------------------
	// Layer selection, sink and further source checks
	// ------------------------------------------------------------------------

	// Sink occasion taken, and a cycle with no occasion
	sequence s_snk_occ;
		ce && dirIn[1].slotEn;
	endsequence

	sequence s_snk_gap;
		ce && !dirIn[1].slotEn;
	endsequence

	// The unselected layer only ever carries idle words
	a_bp_unsel_idle: assert property (ce && tunnelSel |=> bypassAdaptedWords == IDLE_STREAM)
		else $error("unselected bypass layer not idle");
	a_tun_unsel_idle: assert property (ce && !tunnelSel |=> tunnelAdaptedWords == IDLE_STREAM)
		else $error("unselected tunnel layer not idle");
	// Outside occasions the strobe drops and the word is idle
	a_snk_gap_idle: assert property (s_snk_gap |=> !timeSlotClientWords.slotEn
		&& timeSlotClientWords.word == `TSM_IDLE_WORD) else $error("sink output outside an occasion");
	a_src_gap_idle: assert property (ce && !dirIn[0].slotEn && !tunnelSel |=>
		!bypassAdaptedWords.slotEn && bypassAdaptedWords.word == `TSM_IDLE_WORD)
		else $error("source output outside an occasion");
	// Frame alignment survives the one-frame buffer delay
	a_snk_frame_mark: assert property (s_snk_occ ##0 fsW[1] |=> timeSlotClientWords.frameStart)
		else $error("sink frame start not carried");
	// Each direction swaps tables only at its own frame start
	a_src_table_load: assert property (ce && fsW[0] |=> active0W[0] == $past(shadow0W[0]))
		else $error("source table not loaded at frame start");
	a_snk_tbl_hold: assert property (ce && !fsW[1] |=> active0W[1] == $past(active0W[1]))
		else $error("sink table changed inside a frame");
	a_snk_dir_indep: assert property (ce && mgmtSlotTableWe && mgmtSlotTableDir == `TSM_DIR_SNK |=>
		shadow0W[0] == $past(shadow0W[0])) else $error("sink write reached source table");
	// Mapped sink entries in monotonic mode must lie above the last source slot used
	a_snk_mono_order: assert property (s_snk_occ ##0 mapMode == tsm_pkg::TSM_MONOTONIC
		&& mappedW[1] && seenW[1] |-> entryW[1].srcSlot > lastW[1]) else $error("sink monotonic order broken");

endmodule : tsm_slot_mapper

// ==== tsm_defines.svh ====
/*
 * Constants of the TDM slot mapper: frame size, word width, idle marker,
 * elastic store depth and table directions.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef TSM_DEFINES_SVH
`define TSM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Frame and word layout
// ----------------------------------------------------------------------------
`define TSM_SLOT_CNT   16
`define TSM_IDX_W      4
`define TSM_WORD_W     64
// Idle marker pattern carried in a slot word
`define TSM_IDLE_WORD  64'hffff_ffff_ffff_fffe

// ----------------------------------------------------------------------------
// Elastic store and slot table selection
// ----------------------------------------------------------------------------
`define TSM_ES_DEPTH   16
`define TSM_ES_PTR_W   4
`define TSM_ES_CNT_W   5
`define TSM_DIR_SRC    1'b0
`define TSM_DIR_SNK    1'b1

`endif

// ==== tsm_pkg.sv ====
/*
 * Types shared by the TDM slot mapper files.
 * Assumes tsm_defines.svh is on the include path.
 */
`include "tsm_defines.svh"

package tsm_pkg;

	// ------------------------------------------------------------------------
	// Slot stream carried between layers, one word per slot occasion
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic                     frameStart;
		logic                     slotEn;
		logic [`TSM_WORD_W-1:0]   word;
	} tsm_stream_type;

	// ------------------------------------------------------------------------
	// Slot table entry, indexed by destination slot
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic                     excess;
		logic [`TSM_IDX_W-1:0]    srcSlot;
	} tsm_map_entry_type;

	typedef enum logic {
		TSM_MONOTONIC = 1'b0,
		TSM_ARBITRARY = 1'b1
	} tsm_map_mode_type;

endpackage : tsm_pkg

// ==== tsm_async_mapper.sv ====
/*
 * Asynchronous channel mapper: elastic store between an uneven channel word
 * stream and the slot occasions of the time slot layer frame.
 * Assumes frame timing (slot tick, frame start) is synchronous to clk.
 */
`timescale 1ns/10ps
`include "tsm_defines.svh"

module tsm_async_mapper (
	// Clock, reset, enable
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic                    ce,
	// Channel side
	input  wire logic [`TSM_WORD_W-1:0]  asyncChannelWords,
	input  wire logic                    asyncChannelValid,
	// Frame timing
	input  wire logic                    frameStartPulse,
	input  wire logic                    slotTick,
	// Time slot layer side
	output tsm_pkg::tsm_stream_type      tsOut,
	output logic                         esOverflow
);

	logic [`TSM_WORD_W-1:0]  store [0:`TSM_ES_DEPTH-1];
	logic [`TSM_ES_PTR_W-1:0] wrPtr_q;
	logic [`TSM_ES_PTR_W-1:0] rdPtr_q;
	logic [`TSM_ES_CNT_W-1:0] count_q;
	logic [`TSM_IDX_W-1:0]    slotPtr_q;
	logic [`TSM_IDX_W-1:0]    curSlot;
	logic                     isIdle;
	logic                     full;
	logic                     empty;
	logic                     wrOk;
	logic                     rdOk;

	// ------------------------------------------------------------------------
	// Store control
	// ------------------------------------------------------------------------
	assign isIdle  = (asyncChannelWords == `TSM_IDLE_WORD);
	assign full    = (count_q == `TSM_ES_CNT_W'(`TSM_ES_DEPTH));
	assign empty   = (count_q == '0);
	assign wrOk    = asyncChannelValid && !isIdle && !full;
	assign rdOk    = slotTick && !empty;
	assign curSlot = frameStartPulse ? '0 : slotPtr_q;

	// Word storage; idle markers never occupy space
	always_ff @(posedge clk) begin
		if (ce && wrOk) begin
			store[wrPtr_q] <= asyncChannelWords;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else if (ce) begin
			if (wrOk) wrPtr_q <= wrPtr_q + 1'b1;
			if (rdOk) rdPtr_q <= rdPtr_q + 1'b1;
			count_q <= count_q + `TSM_ES_CNT_W'(wrOk) - `TSM_ES_CNT_W'(rdOk);
		end
	end

	// Slot pointer restarts on frame start so the frame-start slot is the first and the next is slot 1
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			slotPtr_q <= '0;
		end else if (ce && slotTick) begin
			slotPtr_q <= curSlot + 1'b1;
		end
	end

	// Slot binding: stored word or idle marker when the store runs dry
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tsOut      <= '{frameStart: 1'b0, slotEn: 1'b0, word: `TSM_IDLE_WORD};
			esOverflow <= 1'b0;
		end else if (ce) begin
			tsOut.slotEn     <= slotTick;
			tsOut.frameStart <= slotTick && (curSlot == '0);
			tsOut.word       <= rdOk ? store[rdPtr_q] : `TSM_IDLE_WORD;
			esOverflow       <= asyncChannelValid && !isIdle && full;
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_idle_discard: assert property (ce && asyncChannelValid && isIdle && !rdOk |=>
		count_q == $past(count_q)) else $error("idle marker entered the store");
	a_empty_idle: assert property (ce && slotTick && empty |=>
		tsOut.slotEn && tsOut.word == `TSM_IDLE_WORD) else $error("empty store gave no idle marker");
	a_frame_restart: assert property (ce && slotTick && frameStartPulse |=>
		tsOut.frameStart ##0 (slotPtr_q == `TSM_IDX_W'(1))) else $error("slot pointer not restarted");

endmodule : tsm_async_mapper

// ==== tsm_far_model.sv ====
/*
 * Far-side model: adaptation functions that feed the slot mapper with the
 * channel, bypass and tunnel slot streams and with the frame timing.
 * Assumes one clock; everything changes 1 ns after a rising edge.
 */
`timescale 1ns/10ps

module tsm_far_model (
	// Clock and stall control
	input  wire logic               clk,
	input  wire logic               run,
	// Streams and timing towards the mapper
	output tsm_pkg::tsm_stream_type syncOut,
	output tsm_pkg::tsm_stream_type bypassOut,
	output tsm_pkg::tsm_stream_type tunnelOut,
	output logic                    slotTick,
	output logic                    frameStartPulse,
	output logic [7:0]              frameNo
);
	logic [3:0] slot = 4'h0;
	logic       phase = 1'b0;
	logic       en = 1'b0;

	// Word carries tag, frame and slot; between occasions the line shows the inverted last word
	function automatic tsm_pkg::tsm_stream_type mk(input logic [7:0] tag, input tsm_pkg::tsm_stream_type last);
		mk.frameStart = en & (slot == 4'h0);
		mk.slotEn     = en;
		mk.word       = en ? {tag, 40'h0, frameNo, 4'h0, slot} : ~last.word;
	endfunction : mk

	// --------------------------------------------------------------------
	// Slot occasion every second cycle, frame start only on slot 0
	// --------------------------------------------------------------------
	initial begin
		syncOut = '0;
		bypassOut = '0;
		tunnelOut = '0;
		slotTick = 1'b0;
		frameStartPulse = 1'b0;
		frameNo = 8'h00;
	end

	// Slot counter holds while stalled, so frame alignment survives a stall
	always @(posedge clk) begin
		#1;
		en = run & ~phase;
		phase = run & ~phase;
		if (en && slot == 4'h0) frameNo = frameNo + 8'h01;
		syncOut = mk(8'h5a, syncOut);
		bypassOut = mk(8'hb1, bypassOut);
		tunnelOut = mk(8'hc3, tunnelOut);
		slotTick = en;
		frameStartPulse = en & (slot == 4'h0);
		slot = slot + {3'h0, en};
	end
endmodule : tsm_far_model

// ==== tb_tsm_slot_mapper.sv ====
/*
 * Self-checking bench of the slot mapper: far model drives the sync, bypass and tunnel streams,
 * a monitor snapshots each output frame, scenario tasks judge them.
 * Assumes the design files and tsm_defines.svh are compiled first.
 */
`timescale 1ns/10ps
`include "tsm_defines.svh"

module tb_tsm_slot_mapper;
	logic                       clk = 1'b0;
	logic                       rstn = 1'b0;
	logic                       run = 1'b0;
	logic                       we = 1'b0;
	logic                       dir = 1'b0;
	logic [3:0]                 idx = 4'h0;
	logic                       asyncValid = 1'b0;
	logic                       chAsync = 1'b0;
	logic                       tunSel = 1'b0;
	logic [`TSM_WORD_W-1:0]     asyncWord = '0;
	tsm_pkg::tsm_map_mode_type  mode = tsm_pkg::TSM_MONOTONIC;
	tsm_pkg::tsm_map_entry_type entry = '0;
	tsm_pkg::tsm_map_entry_type srcT [16], snkT [16], xsT [16];
	tsm_pkg::tsm_stream_type    syncS, bpIn, tnIn, o [3];
	logic                       slotTick, fsPulse, esOvf;
	logic [7:0]                 frameNo, capF [3], snapF [3];
	logic [63:0]                cap [3][16], snap [3][16];
	int                         pos [3], nFr [3];
	int                         mismatches = 0, n_compared = 0, nOvf = 0;

	always #5 clk = ~clk;

	tsm_far_model far (.clk(clk), .run(run), .syncOut(syncS), .bypassOut(bpIn), .tunnelOut(tnIn),
		.slotTick(slotTick), .frameStartPulse(fsPulse), .frameNo(frameNo));

	tsm_slot_mapper uut (.clk(clk), .rstn(rstn), .ce(1'b1), .mapMode(mode), .tunnelSel(tunSel),
		.channelAsync(chAsync), .mgmtSlotTableWe(we), .mgmtSlotTableDir(dir), .mgmtSlotTableIdx(idx),
		.mgmtSlotTableInput(entry), .syncChannelWords(syncS), .asyncChannelWords(asyncWord),
		.asyncChannelValid(asyncValid), .frameStartPulse(fsPulse), .slotTick(slotTick),
		.bypassAdaptedWords(o[0]), .tunnelAdaptedWords(o[1]), .bypassAdaptedIn(bpIn),
		.tunnelAdaptedIn(tnIn), .timeSlotClientWords(o[2]), .esOverflow(esOvf));

	// --------------------------------------------------------------------
	// Monitor: idle words are recorded like data, never flagged
	// --------------------------------------------------------------------
	always @(posedge clk) begin
		if (esOvf === 1'b1) nOvf++;
		for (int i = 0; i < 3; i++) begin
			if (o[i].slotEn === 1'b1) begin
				if (o[i].frameStart === 1'b1) begin
					pos[i] = 0;
					capF[i] = frameNo - 8'h01; // Content is one frame old
				end
				cap[i][pos[i] % 16] = o[i].word;
				if (pos[i] == 15) begin
					snap[i] = cap[i];
					snapF[i] = capF[i];
					nFr[i]++;
				end
				pos[i]++;
			end
		end
	end

	// --------------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------------
	task automatic end_sim;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim

	task automatic give_up(input string what);
		mismatches++;
		$display("Error %s expected completion seen timeout", what);
		end_sim();
	endtask : give_up

	task automatic check(input string what, input logic [65:0] seen, input logic [65:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Sink stream always runs, so its frame count paces every wait
	task automatic wait_frames(input int k);
		int goal;
		goal = nFr[2] + k;
		for (int c = 0; c < 40 * k && nFr[2] < goal; c++) @(posedge clk);
		#1;
		if (nFr[2] < goal) give_up("frame wait");
	endtask : wait_frames

	task automatic load(input logic d, input tsm_pkg::tsm_map_entry_type t [16]);
		for (int k = 0; k < 16; k++) begin
			@(posedge clk);
			#1;
			we = 1'b1;
			dir = d;
			idx = 4'(k);
			entry = t[k];
		end
		@(posedge clk);
		#1;
		we = 1'b0;
	endtask : load

	// Two frame ends guarantee the snapshot was built wholly from the new tables
	task automatic setup(input tsm_pkg::tsm_map_mode_type m, input logic tun);
		mode = m;
		tunSel = tun;
		load(`TSM_DIR_SRC, srcT);
		load(`TSM_DIR_SNK, snkT);
		wait_frames(2);
	endtask : setup

	// Expected frame: excess or out-of-order (monotonic) entries give idle
	task automatic check_frame(input int s, input logic [7:0] tag, input tsm_pkg::tsm_map_entry_type t [16],
		input tsm_pkg::tsm_map_mode_type m);
		logic [63:0] e;
		logic [3:0]  last;
		logic        seen;
		seen = 1'b0;
		last = 4'h0;
		for (int k = 0; k < 16; k++) begin
			e = `TSM_IDLE_WORD;
			if (!t[k].excess && (m == tsm_pkg::TSM_ARBITRARY || !seen || t[k].srcSlot > last)) begin
				e = {tag, 40'h0, snapF[s], 4'h0, t[k].srcSlot};
				seen = 1'b1;
				last = t[k].srcSlot;
			end
			check($sformatf("stream %0d slot %0d", s, k), {2'b00, snap[s][k]}, {2'b00, e});
		end
	endtask : check_frame

	// --------------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------------
	task automatic s_reset;
		for (int s = 0; s < 3; s++) check($sformatf("reset stream %0d", s), o[s], {2'b00, `TSM_IDLE_WORD});
		check("reset overflow", {65'h0, esOvf}, 66'h0);
		run = 1'b1;
		wait_frames(3);
		check_frame(0, 8'h5a, xsT, mode);
		check_frame(2, 8'hb1, xsT, mode);
	endtask : s_reset

	task automatic s_mono;
		for (int k = 0; k < 16; k++) begin
			srcT[k] = {k > 9, 4'(k)};
			snkT[k] = {k > 11, 4'(k + 2)};
		end
		setup(tsm_pkg::TSM_MONOTONIC, 1'b0);
		repeat (2) begin
			check_frame(0, 8'h5a, srcT, mode);
			check_frame(2, 8'hb1, snkT, mode);
			check("tunnel unselected", o[1], {2'b00, `TSM_IDLE_WORD});
			wait_frames(1);
		end
	endtask : s_mono

	task automatic s_refuse;
		for (int k = 0; k < 16; k++) srcT[k] = {1'b0, 4'(k == 5 ? 2 : k)};
		setup(tsm_pkg::TSM_MONOTONIC, 1'b0);
		check_frame(0, 8'h5a, srcT, mode);
	endtask : s_refuse

	// Arbitrary order only towards the tunnel hop whose far end handles it
	task automatic s_arb_tunnel;
		for (int k = 0; k < 16; k++) begin
			srcT[k] = {k == 0, 4'(15 - k)};
			snkT[k] = {k == 3, 4'(k * 7)};
		end
		setup(tsm_pkg::TSM_ARBITRARY, 1'b1);
		check_frame(1, 8'h5a, srcT, mode);
		check_frame(2, 8'hc3, snkT, mode);
		check("bypass unselected", o[0], {2'b00, `TSM_IDLE_WORD});
	endtask : s_arb_tunnel

	// Mid-frame table write must leave the running frame untouched
	task automatic s_boundary;
		for (int k = 0; k < 16; k++) srcT[k] = {1'b0, 4'(k)};
		setup(tsm_pkg::TSM_MONOTONIC, 1'b0);
		for (int c = 0; c < 40 && pos[0] != 4; c++) @(posedge clk);
		#1;
		if (pos[0] < 4 || pos[0] > 6) give_up("slot position wait");
		we = 1'b1;
		dir = `TSM_DIR_SRC;
		idx = 4'hc;
		entry = 5'h10;
		@(posedge clk);
		#1;
		we = 1'b0;
		wait_frames(1);
		check_frame(0, 8'h5a, srcT, mode);
		srcT[12] = 5'h10;
		wait_frames(1);
		check_frame(0, 8'h5a, srcT, mode);
	endtask : s_boundary

	// Store filled past full while slot ticks stall, then drained in order
	task automatic s_async;
		int got;
		got = 0;
		chAsync = 1'b1;
		// Every source slot mapped, so no stored word is lost to an excess slot
		for (int k = 0; k < 16; k++) srcT[k] = {1'b0, 4'(k)};
		setup(tsm_pkg::TSM_MONOTONIC, 1'b0);
		run = 1'b0;
		for (int i = 0; i < 18; i++) begin
			@(posedge clk);
			#1;
			asyncValid = 1'b1;
			asyncWord = (i == 8) ? `TSM_IDLE_WORD : {8'ha7, 48'h0, 8'(i > 8 ? i - 1 : i)};
		end
		@(posedge clk);
		#1;
		asyncValid = 1'b0;
		repeat (3) @(posedge clk);
		check("overflow pulses", 66'(nOvf), 66'd1);
		run = 1'b1;
		repeat (5) begin
			wait_frames(1);
			for (int k = 0; k < 16; k++) begin
				if (snap[0][k][63:56] === 8'ha7) begin
					check("async word", {2'b00, snap[0][k]}, {10'h0a7, 48'h0, 8'(got)});
					got++;
				end
			end
		end
		check("async count", 66'(got), 66'd16);
		check_frame(0, 8'h5a, xsT, mode);
	endtask : s_async

	initial begin
		for (int k = 0; k < 16; k++) xsT[k] = 5'h10;
		repeat (12) @(posedge clk);
		#1;
		rstn = 1'b1;
		s_reset();
		s_mono();
		s_refuse();
		s_arb_tunnel();
		s_boundary();
		s_async();
		end_sim();
	end
endmodule : tb_tsm_slot_mapper
